// file: rtl/rtc_irq_map.vh
// Purpose: Register offsets, field positions and reset values of the RTC interrupt and control block.
// Assumes: 5-bit byte address, 8-bit data, 10 MHz system clock.
// Notes: Included by the block's single design file.
//
// Notes on behaviour
// (RULE1) Output mode top bit: 0 puts power-fail interrupt on multi-function output, 1 crystal.
// (RULE2) Six periodic enables arm interrupts on the matching counter rollover.
// (RULE3) First periodic interrupt after enabling may come early; later ones full period.
// (RULE4) With all six periodic enables zero, no periodic flag or pin interrupt; a periodic flag already set still drives the pin.
// (RULE5) On battery in battery-backed mode, backup-enable bit governs interrupt enables.
// (RULE6) Backup-enable zero: entering standby clears periodic, alarm and power-fail enables.
// (RULE7) Compare enables select comparators; a disabled comparator reports always equal.
// (RULE8) Alarm flag sets when all enabled comparators match; all disabled means no alarm.
// (RULE9) Alarm drives the host interrupt only while the alarm enable is one.
// (RULE10) Power-fail enable one raises an interrupt when battery exceeds main supply.
// (RULE11) Main status at 00H: RAM bits, block select, W1C alarm/periodic, power-fail, summary.
// (RULE12) Alarm and periodic flags clear by writing one; power-fail clears while input high.
// (RULE13) Block 0 address 03H: test mode, oscillator fail/supply, six rollover flags.
// (RULE14) Rollover flags set by rollover events and cleared when the register is read.
// (RULE15) Block 0 address 04H: time save enable, bit 6 reads zero, six RAM bits.
// (RULE16) Block 1 address 01H: RAM, backup enable, start/stop, 12/24, leap counter.
// (RULE17) Block 1 address 02H: top bit crystal output select, seven RAM bits.
// (RULE18) Block 1 address 03H: six periodic interrupt enables, two RAM bits.
// (RULE19) Block 1 address 04H: power-fail, alarm and six compare enables.
// (RULE20) Clock start bit accepts a one only while the oscillator is running.
// (RULE21) Writing zero to supply-mode bit honoured only while oscillator fail reads zero.
// (RULE22) Oscillator-fail/supply bit reads failure status, writes select supply mode.
// (RULE23) Host sets test mode, clears register 1FH, then leaves test mode.
// (RULE24) Host polls oscillator fail for about three seconds after writing clock start.
// (RULE25) Host sets power-fail enable then backup enable once oscillator runs.
// (RULE26) 01H..04H decode by block select at each access; 00H always main status.
`ifndef RTC_IRQ_MAP_VH
`define RTC_IRQ_MAP_VH
`define A_STATUS    5'h00
`define A_MODE      5'h01
`define A_OUTSEL    5'h02
`define A_ROLL      5'h03
`define A_SAVE      5'h04
`define A_TEST      5'h1f
`define B_BLOCK     6
`define B_ALARM     3
`define B_PER       2
`define B_PF        1
`define B_SUM       0
`define B_TEST      7
`define B_OSC       6
`define B_SAVE_EN   7
`define B_BKUP_EN   4
`define B_START     3
`define B_XTAL      7
`define B_PF_EN     7
`define B_AL_EN     6
`define RST_BYTE    8'h00
`define RST_SUPPLY  1'b1
`define ST_RAM_MASK 8'hb0
`define SAVE_MASK   8'hbf
`endif

// file: rtl/rtc_irq_regs.v
// Purpose: Control/status registers and interrupt gating of a real-time clock.
// Assumes: Host port on the system clock; counter events are same-clock one-cycle pulses.
// Notes: Time counters, compare RAM and supply switching live outside this block.
`include "rtc_irq_map.vh"
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_regs (
	input  wire       CLOCK_I,
	input  wire       RSTN_I,
	input  wire [4:0] ADDR_I,
	input  wire [7:0] WDATA_I,
	input  wire       WR_I,
	input  wire       RD_I,
	output reg  [7:0] RDATA_O,
	input  wire [5:0] ROLLOVER_I,
	input  wire [5:0] COMPARE_EQ_I,
	input  wire       SUPPLY_LOSS_INPUT_I,
	input  wire       BATTERY_SUPPLY_HIGH_I,
	input  wire       OSC_RUNNING_I,
	input  wire       XTAL_CLK_I,
	output reg        HOST_INTERRUPT_PIN_O,
	output reg        MULTI_FUNCTION_OUTPUT_O,
	output reg        CLOCK_RUN_O,
	output reg        HOUR12_O,
	output reg  [1:0] LEAP_COUNT_O,
	output reg        TIME_SAVE_EN_O,
	output reg        SINGLE_SUPPLY_O,
	output reg        TEST_MODE_O,
	output reg  [5:0] COMPARE_EN_O
);
	// Asynchronous pins pass two flops before any logic reads them
	reg [1:0] pf_s_q;
	reg [1:0] bat_s_q;
	reg [1:0] osc_s_q;
	reg [1:0] xt_s_q;
	always @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			pf_s_q  <= 2'h0;
			bat_s_q <= 2'h0;
			osc_s_q <= 2'h0;
			xt_s_q  <= 2'h0;
		end else begin
			pf_s_q  <= {pf_s_q[0], SUPPLY_LOSS_INPUT_I};
			bat_s_q <= {bat_s_q[0], BATTERY_SUPPLY_HIGH_I};
			osc_s_q <= {osc_s_q[0], OSC_RUNNING_I};
			xt_s_q  <= {xt_s_q[0], XTAL_CLK_I};
		end
	end
	wire supply_loss_high = pf_s_q[1];
	wire on_battery       = bat_s_q[1];
	wire osc_ok           = osc_s_q[1];

	// Register state
	reg       block_select_bit_q;
	reg [2:0] status_ram_q;
	reg       alarm_flag_q;
	reg       per_flag_q;
	reg       pf_flag_q;
	reg [5:0] roll_q;
	reg       test_q;
	reg       osc_fail_q;
	reg       supply_q;
	reg [7:0] save_q;
	reg [7:0] mode_q;
	reg [7:0] outsel_q;
	reg [7:0] per_en_q;
	reg [7:0] alpf_en_q;
	reg       standby_q;

	// Decode: 00H is fixed, 01H..04H follow the block select bit
	wire is_status = (ADDR_I == `A_STATUS);
	wire blk1      = block_select_bit_q;
	wire hit_mode  = (ADDR_I == `A_MODE)   &  blk1;         // [RULE26] [RULE16]
	wire hit_out   = (ADDR_I == `A_OUTSEL) &  blk1;         // [RULE17]
	wire hit_roll  = (ADDR_I == `A_ROLL)   & ~blk1;         // [RULE13]
	wire hit_pen   = (ADDR_I == `A_ROLL)   &  blk1;         // [RULE18]
	wire hit_save  = (ADDR_I == `A_SAVE)   & ~blk1;         // [RULE15]
	wire hit_aen   = (ADDR_I == `A_SAVE)   &  blk1;         // [RULE19]

	// Interrupt sources
	wire [5:0] cmp_en    = alpf_en_q[5:0];
	wire       all_match = &(COMPARE_EQ_I | ~cmp_en);       // Disabled comparator = equal [RULE7]
	wire       alarm_evt = (|cmp_en) & all_match;           // [RULE8]
	wire       per_evt   = |(ROLLOVER_I & per_en_q[5:0]);   // [RULE2] [RULE3] [RULE4]
	wire       pf_evt    = on_battery;
	// Pin interrupt: alarm and power-fail flags gated by their enables, periodic flag ungated
	wire irq_pin = (alarm_flag_q & alpf_en_q[`B_AL_EN])     // [RULE9]
		| per_flag_q                                    // [RULE4]
		| (pf_flag_q & alpf_en_q[`B_PF_EN]);            // [RULE10]
	wire pf_on_mfo = ~outsel_q[`B_XTAL] & pf_flag_q & alpf_en_q[`B_PF_EN];
	wire summary   = irq_pin | pf_on_mfo;
	// Standby entry in battery-backed mode without the backup enable clears enables
	wire standby_clr = on_battery & ~standby_q & ~supply_q & ~mode_q[`B_BKUP_EN]; // [RULE5] [RULE6]
	wire w1c_alarm   = WR_I & is_status & WDATA_I[`B_ALARM];
	wire w1c_per     = WR_I & is_status & WDATA_I[`B_PER];

	// Status flags: a set in the same cycle as a clear wins, except power-fail, where input high clears
	always @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			alarm_flag_q <= 1'b0;
			per_flag_q   <= 1'b0;
			pf_flag_q    <= 1'b0;
			roll_q       <= 6'h00;
			standby_q    <= 1'b0;
		end else begin
			standby_q <= on_battery;
			if (alarm_evt)
				alarm_flag_q <= 1'b1;                   // [RULE8]
			else if (w1c_alarm)
				alarm_flag_q <= 1'b0;                   // [RULE12]
			if (per_evt)
				per_flag_q <= 1'b1;                     // [RULE2]
			else if (w1c_per)
				per_flag_q <= 1'b0;                     // [RULE12]
			// Input high means main power fine, so the flag cannot persist
			if (supply_loss_high)
				pf_flag_q <= 1'b0;                      // [RULE12]
			else if (pf_evt)
				pf_flag_q <= 1'b1;                      // [RULE10]
			// Read clears, except bits whose event lands this cycle [RULE14]
			if (RD_I & hit_roll)
				roll_q <= ROLLOVER_I;
			else
				roll_q <= roll_q | ROLLOVER_I;
		end
	end

	// Software-written registers
	always @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			block_select_bit_q <= 1'b0;
			status_ram_q       <= 3'h0;
			test_q             <= 1'b0;
			osc_fail_q         <= 1'b1;
			supply_q           <= `RST_SUPPLY;
			save_q             <= `RST_BYTE;
			mode_q             <= `RST_BYTE;
			outsel_q           <= `RST_BYTE;
			per_en_q           <= `RST_BYTE;
			alpf_en_q          <= `RST_BYTE;
		end else begin
			// Oscillator loss sets the fail flag and stops the clock
			if (!osc_ok) begin
				osc_fail_q <= 1'b1;
				supply_q   <= 1'b1;
				mode_q[`B_START] <= 1'b0;
			end
			if (WR_I & is_status) begin
				block_select_bit_q <= WDATA_I[`B_BLOCK];
				status_ram_q <= {WDATA_I[7], WDATA_I[5:4]};  // [RULE11]
			end
			if (WR_I & hit_roll) begin
				test_q <= WDATA_I[`B_TEST];
				// Battery-backed select refused while fail flag reads one
				if (WDATA_I[`B_OSC])
					supply_q <= 1'b1;               // [RULE22]
				else if (!osc_fail_q && osc_ok)
					supply_q <= 1'b0;               // [RULE21]
			end
			if (WR_I & hit_save)
				save_q <= WDATA_I & `SAVE_MASK;         // [RULE15]
			if (WR_I & hit_mode) begin
				mode_q[7:4] <= WDATA_I[7:4];
				mode_q[2:0] <= WDATA_I[2:0];
				// Start only latches with a running oscillator; clears fail flag
				if (osc_ok) begin
					mode_q[`B_START] <= WDATA_I[`B_START];  // [RULE20]
					if (WDATA_I[`B_START])
						osc_fail_q <= 1'b0;
				end else
					mode_q[`B_START] <= 1'b0;       // [RULE20]
			end
			if (WR_I & hit_out)
				outsel_q <= WDATA_I;                    // [RULE17]
			if (standby_clr) begin
				per_en_q[5:0]  <= 6'h00;                // [RULE6]
				alpf_en_q[7:6] <= 2'h0;                 // [RULE6]
			end else begin
				if (WR_I & hit_pen)
					per_en_q <= WDATA_I;            // [RULE18]
				if (WR_I & hit_aen)
					alpf_en_q <= WDATA_I;           // [RULE19]
			end
		end
	end

	// Read mux, data one cycle after the strobe; unmapped reads zero
	reg [7:0] rd_d;
	always @* begin
		rd_d = 8'h00;
		if (is_status)
			rd_d = ({status_ram_q[2], 1'b0, status_ram_q[1:0], 4'h0} & `ST_RAM_MASK)
				| {1'b0, block_select_bit_q, 2'h0, alarm_flag_q,
				per_flag_q, pf_flag_q, summary};    // [RULE11]
		else if (hit_roll)
			rd_d = {test_q, osc_fail_q, roll_q};        // [RULE22] [RULE13]
		else if (hit_save)
			rd_d = save_q;
		else if (hit_mode)
			rd_d = mode_q;
		else if (hit_out)
			rd_d = outsel_q;
		else if (hit_pen)
			rd_d = per_en_q;
		else if (hit_aen)
			rd_d = alpf_en_q;
	end

	// Registered outputs
	always @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			RDATA_O                 <= 8'h00;
			HOST_INTERRUPT_PIN_O    <= 1'b0;
			MULTI_FUNCTION_OUTPUT_O <= 1'b0;
			CLOCK_RUN_O             <= 1'b0;
			HOUR12_O                <= 1'b0;
			LEAP_COUNT_O            <= 2'h0;
			TIME_SAVE_EN_O          <= 1'b0;
			SINGLE_SUPPLY_O         <= 1'b1;
			TEST_MODE_O             <= 1'b0;
			COMPARE_EN_O            <= 6'h00;
		end else begin
			RDATA_O <= RD_I ? rd_d : 8'h00;
			HOST_INTERRUPT_PIN_O <= irq_pin;
			// Crystal copy is sampled, so it is only a coarse buffered image
			MULTI_FUNCTION_OUTPUT_O <= outsel_q[`B_XTAL] ? xt_s_q[1] : pf_on_mfo; // [RULE1]
			CLOCK_RUN_O     <= mode_q[`B_START];
			HOUR12_O        <= mode_q[2];
			LEAP_COUNT_O    <= mode_q[1:0];
			TIME_SAVE_EN_O  <= save_q[`B_SAVE_EN];
			SINGLE_SUPPLY_O <= supply_q;
			TEST_MODE_O     <= test_q;
			COMPARE_EN_O    <= cmp_en;
		end
	end
endmodule // rtc_irq_regs
`default_nettype wire

// file: dv/rtc_irq_regs_monitor.sv
// Purpose: Port-level assertions for the RTC control block.
// Assumes: One-cycle host strobes; block select shadowed from writes to 00.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_regs_monitor (
	input wire logic       CLOCK_I,
	input wire logic       RSTN_I,
	input wire logic [4:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic       WR_I,
	input wire logic       RD_I,
	input wire logic [7:0] RDATA_O,
	input wire logic       SUPPLY_LOSS_INPUT_I,
	input wire logic       OSC_RUNNING_I,
	input wire logic       CLOCK_RUN_O,
	input wire logic       HOUR12_O,
	input wire logic [1:0] LEAP_COUNT_O,
	input wire logic       TEST_MODE_O,
	input wire logic [5:0] COMPARE_EN_O
);
	logic blk_q;
	// Shadow of block select, so decode checks know which bank is live
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I)
			blk_q <= 1'b0;
		else if (WR_I && ADDR_I == 5'h00)
			blk_q <= WDATA_I[6];
	end
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RSTN_I);
	AST_BLK: assert property (RD_I && ADDR_I == 5'h00 |=> RDATA_O[6] == blk_q)
		else $error("block select readback wrong");
	AST_UNMAP: assert property (RD_I && ADDR_I == 5'h1f |=> RDATA_O == 8'h00)
		else $error("unmapped read not zero");
	AST_SAVE6: assert property (RD_I && ADDR_I == 5'h04 && !blk_q |=> !RDATA_O[6])
		else $error("save bit 6 not zero");
	// Register then output flop: the image shows two edges after the write
	AST_TEST: assert property (WR_I && ADDR_I == 5'h03 && !blk_q |=> ##1
		TEST_MODE_O == $past(WDATA_I[7], 2))
		else $error("test mode image wrong");
	AST_MODE: assert property (WR_I && ADDR_I == 5'h01 && blk_q |=> ##1
		HOUR12_O == $past(WDATA_I[2], 2) && LEAP_COUNT_O == $past(WDATA_I[1:0], 2))
		else $error("mode image wrong");
	AST_CMP: assert property (WR_I && ADDR_I == 5'h04 && blk_q |=> ##1
		COMPARE_EN_O == $past(WDATA_I[5:0], 2))
		else $error("compare enables wrong");
	// Synchroniser, start register and output flop make four quiet samples the exact minimum
	AST_START: assert property (!OSC_RUNNING_I [*4] |=> !$rose(CLOCK_RUN_O))
		else $error("clock started without oscillator");
	AST_PF: assert property (SUPPLY_LOSS_INPUT_I [*4] ##0 RD_I && ADDR_I == 5'h00 |=> !RDATA_O[1])
		else $error("power fail flag kept with input high");
endmodule // rtc_irq_regs_monitor
bind rtc_irq_regs rtc_irq_regs_monitor u_mon (.CLOCK_I, .RSTN_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
	.RDATA_O, .SUPPLY_LOSS_INPUT_I, .OSC_RUNNING_I, .CLOCK_RUN_O, .HOUR12_O, .LEAP_COUNT_O,
	.TEST_MODE_O, .COMPARE_EN_O);
`default_nettype wire

// file: dv/rtc_env_model.sv
// Purpose: Time base and oscillator stand-in facing the RTC control block.
// Assumes: Bench commands change just after a rising edge.
// Notes: Crystal copy stands still while the oscillator is off.
`timescale 1ns/1ps
`default_nettype none
module rtc_env_model (
	input  wire logic       clk,
	input  wire logic       osc_on,
	input  wire logic [5:0] roll_go,
	output var  logic       osc_run,
	output var  logic       xtal,
	output var  logic [5:0] rollover
);
	// One-cycle rollover pulses; crystal at half the system rate
	always @(posedge clk) begin
		osc_run <= osc_on;
		if (osc_on)
			xtal <= ~xtal;
		rollover <= roll_go;
	end
	initial begin
		osc_run = 1'b0;
		xtal = 1'b0;
		rollover = 6'h00;
	end
endmodule // rtc_env_model
`default_nettype wire

// file: dv/tb_rtc_irq_regs.sv
// Purpose: Register-level regression of the RTC control block.
// Assumes: Host strobes one cycle; read data stands in the cycle after.
// Notes: Waits cover the two-flop synchronisers and the pin flop.
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_irq_regs;
	logic       clk, rstn, wr_s, rd_s, osc_on, sup_ok, batt_hi;
	logic [4:0] addr;
	logic [7:0] wdata;
	logic [5:0] roll_go, cmp_eq;
	wire  logic [7:0] rdata;
	wire  logic [5:0] rollover;
	wire  logic       pin, multi_function_output, run, single, osc_run, xtal;
	int         n_mismatch, checks_done;
	rtc_irq_regs u_rtc_irq_regs (.CLOCK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .ROLLOVER_I(rollover), .COMPARE_EQ_I(cmp_eq),
		.SUPPLY_LOSS_INPUT_I(sup_ok), .BATTERY_SUPPLY_HIGH_I(batt_hi), .OSC_RUNNING_I(osc_run),
		.XTAL_CLK_I(xtal), .HOST_INTERRUPT_PIN_O(pin), .MULTI_FUNCTION_OUTPUT_O(multi_function_output),
		.CLOCK_RUN_O(run), .HOUR12_O(), .LEAP_COUNT_O(), .TIME_SAVE_EN_O(),
		.SINGLE_SUPPLY_O(single), .TEST_MODE_O(), .COMPARE_EN_O());
	rtc_env_model u_rtc_env_model (.clk(clk), .osc_on(osc_on), .roll_go(roll_go),
		.osc_run(osc_run), .xtal(xtal), .rollover(rollover));
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	// Read data is looked at only in the one cycle it stands
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 cmp("rdata", e, rdata);
	endtask
	task automatic pulse(input logic [5:0] m);
		@(posedge clk);
		roll_go <= m;
		@(posedge clk);
		roll_go <= 6'h00;
		idle(4);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Watchdog well past the fewer than two hundred cycles the tests need
	initial begin
		#2000000;
		n_mismatch++;
		close_out();
	end
	initial begin
		{rstn, wr_s, rd_s, osc_on, batt_hi, addr, wdata, roll_go, cmp_eq} = '0;
		sup_ok = 1'b1;
		n_mismatch = 0;
		checks_done = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		idle(1);
		cmp("single", 8'h01, single);
		rd(5'h03, 8'h40);
		wr(5'h03, 8'h80);
		wr(5'h1f, 8'h00);
		wr(5'h03, 8'h00);
		rd(5'h1f, 8'h00);
		cmp("single", 8'h01, single);
		wr(5'h04, 8'hff);
		rd(5'h04, 8'hbf);
		wr(5'h00, 8'h40);
		wr(5'h01, 8'h08);
		idle(1);
		cmp("run", 8'h00, run);
		osc_on <= 1'b1;
		// Bounded start loop: retry the start write until the clock runs
		for (int i = 0; i < 8 && run !== 1'b1; i++) begin
			wr(5'h01, 8'h08);
			idle(1);
		end
		cmp("run", 8'h01, run);
		wr(5'h00, 8'h00);
		rd(5'h03, 8'h00);
		wr(5'h03, 8'h00);
		idle(1);
		cmp("single", 8'h00, single);
		$display("test oscillator done");
		wr(5'h00, 8'h40);
		wr(5'h03, 8'h04);
		pulse(6'h04);
		cmp("pin", 8'h01, pin);
		rd(5'h00, 8'h45);
		wr(5'h00, 8'h44);
		idle(3);
		cmp("pin", 8'h00, pin);
		wr(5'h03, 8'hc0);
		rd(5'h03, 8'hc0);
		pulse(6'h3f);
		cmp("pin", 8'h00, pin);
		rd(5'h00, 8'h40);
		wr(5'h00, 8'h00);
		rd(5'h03, 8'h3f);
		rd(5'h03, 8'h00);
		$display("test periodic done");
		wr(5'h00, 8'h40);
		wr(5'h04, 8'h41);
		cmp_eq <= 6'h01;
		idle(4);
		cmp("pin", 8'h01, pin);
		rd(5'h00, 8'h49);
		cmp_eq <= 6'h00;
		wr(5'h04, 8'h01);
		wr(5'h00, 8'h48);
		cmp_eq <= 6'h01;
		idle(4);
		cmp("pin", 8'h00, pin);
		rd(5'h00, 8'h48);
		// All comparators report equal, yet no enable means no alarm
		cmp_eq <= 6'h3f;
		wr(5'h04, 8'h00);
		wr(5'h00, 8'h48);
		idle(4);
		rd(5'h00, 8'h40);
		cmp_eq <= 6'h00;
		$display("test alarm done");
		wr(5'h02, 8'h00);
		wr(5'h04, 8'h80);
		wr(5'h01, 8'h18);
		sup_ok <= 1'b0;
		batt_hi <= 1'b1;
		idle(6);
		cmp("pin", 8'h01, pin);
		cmp("mfo", 8'h01, multi_function_output);
		rd(5'h04, 8'h80);
		batt_hi <= 1'b0;
		sup_ok <= 1'b1;
		idle(6);
		cmp("pin", 8'h00, pin);
		wr(5'h01, 8'h08);
		wr(5'h03, 8'h01);
		wr(5'h04, 8'hc1);
		batt_hi <= 1'b1;
		idle(6);
		rd(5'h04, 8'h01);
		rd(5'h03, 8'h00);
		batt_hi <= 1'b0;
		$display("test standby done");
		close_out();
	end
endmodule // tb_rtc_irq_regs
`default_nettype wire
